/* File: logic/adc_conversion_sequencer.sv */
// Conversion sequencer with Avalon-MM control and status registers
// Function
// [RQ1] Hold all logic in reset until power-on reset releases, then initialise.
// [RQ2] Finish start-up about 600 us after reset release.
// [RQ3] After start-up enter idle and accept mode requests.
// [RQ4] Decimate modulator bitstream with a third-order sinc filter.
// [RQ5] First filter notch at three times data rate, then its multiples.
// [RQ6] Notches scale with the modulator clock.
// [RQ7] Four-bit mode: 0 idle, 1 sleep, F boot; 8..B and E unused.
// [RQ8] Single modes: 2 plain, 4 chopped, 6 chopped with excitation swap.
// [RQ9] Continuous modes: 3 plain, 5 chopped, 7 chopped with excitation swap.
// [RQ10] C offset calibration, D gain calibration; both end in idle, mode 0.
// [RQ11] Continuous modes clear not-ready after each conversion, staying put.
// [RQ12] One basic period is oversampling ratio modulator clocks.
// [RQ13] Correction after each conversion takes 40 oscillator periods.
// [RQ14] Gain coefficient computation takes 70 oscillator periods.
// [RQ15] With analog block on, operation starts after 10 us set-up.
// [RQ16] Analog block powering up needs a 70 us wake-up wait.
// [RQ17] Not-ready reads one while converting, zero once complete.
// [RQ18] Single conversion stores result then returns to idle, mode 0.
// [RQ19] Plain single conversion completes after three basic periods.
// [RQ20] Writes of unused mode codes leave the operating state unchanged.
`include "sequencer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer
    import sequencer_pkg::*;
#(
    parameter int STARTUP_CYC = `STARTUP_CYC,
    parameter int WAKE_CYC    = `WAKE_CYC,
    parameter int OSC_DIV     = `OSC_DIV_DEFAULT,
    parameter int ACC_W       = 29
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        modulator_bit,
    output var  logic        not_ready_flag,
    output var  logic        chop_swap,
    output var  logic        excitation_swap,
    output var  logic        analog_power
);
    localparam int SETUP_CYC = `SETUP_CYC;

    seq_state_t  state_r, state_nxt;
    logic [3:0]  mode_r, mode_nxt;
    logic [1:0]  osr_sel_r, osr_sel_nxt, clkdiv_r, clkdiv_nxt;
    logic        auto_sleep_r;
    logic [17:0] delay_cnt_r, delay_nxt, warm_cnt_r;
    logic [6:0]  osc_cnt_r, osc_nxt;
    logic [2:0]  period_cnt_r, period_nxt;
    logic [23:0] half_r, half_nxt, raw_r, raw_nxt, data_r, data_nxt;
    logic [23:0] offset_r, offset_nxt, gain_r, gain_nxt;
    logic        not_ready_r, not_ready_nxt, chop_r, chop_nxt;
    logic        filt_clear, mod_bit_s1_r, mod_bit_s2_r;
    logic        osc_tick, mod_tick, dec_valid;
    logic [ACC_W-1:0] dec_data;

    // Bus decode; one wait cycle, so every access is answered at cycle 1
    wire wr_en   = avs_write && !avs_waitrequest;
    wire ctrl_wr = wr_en && (avs_address == `CTRL_OFS) && avs_byteenable[0];
    wire opt_wr  = wr_en && (avs_address == `OPTION_OFS) && avs_byteenable[0];
    wire [3:0] new_mode = avs_writedata[`MODE_FIELD];
    wire mode_take = ctrl_wr && !mode_unused(new_mode) &&
                     (state_r != ST_BOOT); // RQ20 RQ3
    wire analog_warm = (warm_cnt_r == 18'h00000);
    wire [9:0] osr_val = `OSR_MAX >> osr_sel_r;
    wire [2:0] periods_need = is_chop(mode_r) ? 3'(`PERIODS_CHOP)
                                              : 3'(`PERIODS_PLAIN);
    wire [23:0] dec_word = dec_data[ACC_W-1 -: 24];
    wire [24:0] chop_diff = {half_r[23], half_r} - {dec_word[23], dec_word};
    wire [23:0] corrected = raw_r - offset_r;
    wire analog_on = (state_r != ST_BOOT) && (state_r != ST_SLEEP) &&
                     !((state_r == ST_IDLE) && auto_sleep_r);
    wire [31:0] status_word = {25'h0, 4'(state_r), (state_r != ST_BOOT),
                               analog_on, not_ready_r};
    wire [31:0] rd_word =
        (avs_address == `CTRL_OFS)   ? {24'h0, clkdiv_r, osr_sel_r, mode_r} :
        (avs_address == `OPTION_OFS) ? {31'h0, auto_sleep_r} :
        (avs_address == `STATUS_OFS) ? status_word :
        (avs_address == `DATA_OFS)   ? {8'h0, data_r} :
        (avs_address == `OFFSET_OFS) ? {8'h0, offset_r} :
        (avs_address == `GAIN_OFS)   ? {8'h0, gain_r} : 32'h0000_0000;

    osc_tick_gen #(.OSC_DIV(OSC_DIV)) u_ticks (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkdiv   (clkdiv_r),
        .osc_tick (osc_tick),
        .mod_tick (mod_tick)
    );

    sinc3_decimator #(.ACC_W(ACC_W)) u_filter (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clear     (filt_clear),
        .mod_tick  (mod_tick),
        .bit_in    (mod_bit_s2_r),
        .oversampling_ratio       (osr_val),
        .dec_valid (dec_valid),
        .dec_data  (dec_data)
    );

    always_comb begin
        state_nxt     = state_r;
        mode_nxt      = mode_r;
        osr_sel_nxt   = osr_sel_r;
        clkdiv_nxt    = clkdiv_r;
        delay_nxt     = delay_cnt_r;
        osc_nxt       = osc_cnt_r;
        period_nxt    = period_cnt_r;
        half_nxt      = half_r;
        raw_nxt       = raw_r;
        data_nxt      = data_r;
        offset_nxt    = offset_r;
        gain_nxt      = gain_r;
        not_ready_nxt = not_ready_r;
        chop_nxt      = chop_r;
        filt_clear    = 1'b0;
        case (state_r)
            ST_BOOT: begin
                if (delay_cnt_r == 18'h00000) begin
                    state_nxt = ST_IDLE; // RQ3
                    mode_nxt  = `MODE_IDLE;
                end else begin
                    delay_nxt = delay_cnt_r - 18'h00001; // RQ2
                end
            end
            ST_SETTLE: begin
                if (delay_cnt_r == 18'h00000) begin
                    state_nxt  = ST_CONVERT;
                    filt_clear = 1'b1;
                    period_nxt = 3'h0;
                end else begin
                    delay_nxt = delay_cnt_r - 18'h00001;
                end
            end
            ST_CONVERT: begin
                if (dec_valid) begin
                    if (period_cnt_r == periods_need - 3'h1) begin // RQ12 RQ19
                        state_nxt     = ST_CORRECT;
                        osc_nxt       = 7'(`TCAL_OSC - 1);
                        not_ready_nxt = 1'b1;
                        chop_nxt      = 1'b0;
                        raw_nxt = is_chop(mode_r) ? chop_diff[24:1] : dec_word;
                    end else begin
                        period_nxt = period_cnt_r + 3'h1;
                        // Halfway through a chopped conversion swap inputs
                        if (period_cnt_r == 3'(`PERIODS_PLAIN - 1)) begin // RQ8 RQ9
                            half_nxt = dec_word;
                            chop_nxt = 1'b1;
                        end
                    end
                end
            end
            ST_CORRECT: begin
                if (osc_tick && osc_cnt_r == 7'h00) begin // RQ13
                    if (mode_r == `MODE_CAL_OFS) begin // RQ10
                        offset_nxt    = raw_r;
                        mode_nxt      = `MODE_IDLE;
                        state_nxt     = ST_IDLE;
                        not_ready_nxt = 1'b0;
                    end else if (mode_r == `MODE_CAL_GAIN) begin
                        state_nxt = ST_DIVIDE;
                        osc_nxt   = 7'(`TDIV_OSC - 1);
                    end else begin
                        data_nxt      = corrected;
                        not_ready_nxt = 1'b0; // RQ11 RQ17
                        if (is_single(mode_r)) begin // RQ18
                            mode_nxt  = `MODE_IDLE;
                            state_nxt = ST_IDLE;
                        end else begin
                            state_nxt  = ST_CONVERT; // RQ11
                            filt_clear = 1'b1;
                            period_nxt = 3'h0;
                        end
                    end
                end else if (osc_tick) begin
                    osc_nxt = osc_cnt_r - 7'h01;
                end
            end
            ST_DIVIDE: begin
                if (osc_tick && osc_cnt_r == 7'h00) begin // RQ14
                    gain_nxt      = corrected;
                    mode_nxt      = `MODE_IDLE; // RQ10
                    state_nxt     = ST_IDLE;
                    not_ready_nxt = 1'b0;
                end else if (osc_tick) begin
                    osc_nxt = osc_cnt_r - 7'h01;
                end
            end
            ST_IDLE, ST_SLEEP: begin
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (ctrl_wr) begin
            osr_sel_nxt = avs_writedata[`OSR_FIELD];
            clkdiv_nxt  = avs_writedata[`CLKDIV_FIELD];
        end
        // A host write wins over the sequencer's own return to idle
        if (mode_take) begin // RQ7
            mode_nxt = new_mode;
            chop_nxt = 1'b0;
            if (is_op(new_mode)) begin
                state_nxt     = ST_SETTLE;
                not_ready_nxt = 1'b1; // RQ17
                delay_nxt = analog_warm ? 18'(SETUP_CYC - 1)   // RQ15
                                        : 18'(WAKE_CYC - 1);   // RQ16
            end else begin
                state_nxt = (new_mode == `MODE_SLEEP) ? ST_SLEEP : ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin // RQ1
            state_r     <= ST_BOOT;
            mode_r      <= `MODE_BOOT; // RQ7
            delay_cnt_r <= 18'(STARTUP_CYC - 1); // RQ2
            osr_sel_r   <= `OSR_SEL_RST;
            clkdiv_r    <= `CLKDIV_RST;
            not_ready_r <= 1'b1;
            chop_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            mode_r      <= mode_nxt;
            delay_cnt_r <= delay_nxt;
            osr_sel_r   <= osr_sel_nxt;
            clkdiv_r    <= clkdiv_nxt;
            not_ready_r <= not_ready_nxt;
            chop_r      <= chop_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            {osc_cnt_r, period_cnt_r} <= '0;
            {half_r, raw_r, data_r, offset_r, gain_r} <= '0;
        end else begin
            osc_cnt_r    <= osc_nxt;
            period_cnt_r <= period_nxt;
            half_r       <= half_nxt;
            raw_r        <= raw_nxt;
            data_r       <= data_nxt;
            offset_r     <= offset_nxt;
            gain_r       <= gain_nxt;
        end
    end

    // Wake-up timer restarts whenever the analog block is off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            warm_cnt_r   <= 18'(WAKE_CYC - 1);
            auto_sleep_r <= `ANALOG_AUTO_SLEEP_RST;
            analog_power <= 1'b0;
        end else begin
            if (opt_wr) begin
                auto_sleep_r <= avs_writedata[`ANALOG_AUTO_SLEEP_BIT];
            end
            analog_power <= analog_on;
            if (!analog_on) begin
                warm_cnt_r <= 18'(WAKE_CYC - 1);
            end else if (!analog_warm) begin
                warm_cnt_r <= warm_cnt_r - 18'h00001; // RQ16
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            mod_bit_s1_r    <= 1'b0;
            mod_bit_s2_r    <= 1'b0;
            not_ready_flag  <= 1'b1;
            chop_swap       <= 1'b0;
            excitation_swap <= 1'b0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_word;
            end
            mod_bit_s1_r    <= modulator_bit;
            mod_bit_s2_r    <= mod_bit_s1_r;
            not_ready_flag  <= not_ready_nxt;
            chop_swap       <= chop_nxt;
            excitation_swap <= chop_nxt && is_iex(mode_nxt); // RQ8 RQ9
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A host abort during the divide is not a calibration end
    sequence s_div_done;
        (state_r == ST_DIVIDE && !mode_take) ##1 state_r == ST_IDLE;
    endsequence
    sequence s_enter_correct;
        state_r == ST_CONVERT ##1 state_r == ST_CORRECT;
    endsequence

    a_boot_mode_code: assert property ( // RQ7
        (state_r == ST_BOOT) |-> (mode_r == `MODE_BOOT))
        else $error("mode not boot code during start-up");
    a_boot_to_idle: assert property ( // RQ2
        (state_r == ST_BOOT && delay_cnt_r == 18'h00000) |=>
        (state_r == ST_IDLE && mode_r == `MODE_IDLE))
        else $error("start-up did not end in idle");
    a_unused_kept: assert property ( // RQ20
        (ctrl_wr && mode_unused(new_mode) &&
         (state_r == ST_IDLE || state_r == ST_SLEEP)) |=>
        (mode_r == $past(mode_r) && state_r == $past(state_r)))
        else $error("unused mode code changed state");
    a_setup_delay: assert property ( // RQ15
        (mode_take && is_op(new_mode) && analog_warm) |=>
        (state_r == ST_SETTLE && delay_cnt_r == 18'(SETUP_CYC - 1)))
        else $error("set-up delay not loaded");
    a_wake_delay: assert property ( // RQ16
        (mode_take && is_op(new_mode) && !analog_warm) |=>
        (state_r == ST_SETTLE && delay_cnt_r == 18'(WAKE_CYC - 1)))
        else $error("wake-up delay not loaded");
    a_correct_len: assert property ( // RQ13
        s_enter_correct |-> (osc_cnt_r == 7'(`TCAL_OSC - 1)))
        else $error("correction time not loaded");
    a_div_to_idle: assert property ( // RQ10
        s_div_done |-> (mode_r == `MODE_IDLE && !not_ready_r))
        else $error("calibration did not end in idle");
    a_div_len: assert property ( // RQ14
        (state_r == ST_CORRECT ##1 state_r == ST_DIVIDE) |->
        (osc_cnt_r == 7'(`TDIV_OSC - 1)))
        else $error("divide time not loaded");
    a_single_idle: assert property ( // RQ18
        (state_r == ST_CORRECT && osc_tick && osc_cnt_r == 7'h00 &&
         is_single(mode_r) && !mode_take) |=>
        (mode_r == `MODE_IDLE && state_r == ST_IDLE && !not_ready_flag))
        else $error("single conversion did not return to idle");
    a_cont_stays: assert property ( // RQ11
        (state_r == ST_CORRECT && osc_tick && osc_cnt_r == 7'h00 &&
         !is_single(mode_r) && !mode_r[3] && !mode_take) |=>
        (state_r == ST_CONVERT && mode_r == $past(mode_r) && !not_ready_flag))
        else $error("continuous conversion left its mode");
    a_periods_done: assert property ( // RQ19
        (state_r == ST_CONVERT && dec_valid && !mode_take &&
         period_cnt_r == periods_need - 3'h1) |=> (state_r == ST_CORRECT))
        else $error("conversion period count wrong");
    a_busy_flag: assert property ( // RQ17
        (state_r == ST_SETTLE) |-> not_ready_r)
        else $error("not-ready low while conversion pending");
endmodule : adc_conversion_sequencer

`default_nettype wire

/* File: logic/osc_tick_gen.sv */
// Oscillator and modulator clock enables derived from the system clock
`timescale 1ns/1ps
`default_nettype none

module osc_tick_gen #(
    parameter int OSC_DIV = 100
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] clkdiv,
    output var  logic       osc_tick,
    output var  logic       mod_tick
);
    logic [15:0] osc_cnt_r;
    logic [3:0]  mod_cnt_r;
    wire         osc_wrap = (osc_cnt_r == 16'h0000);

    // Modulator runs at oscillator / 2^(clkdiv+1), so notches track it
    always_ff @(posedge clk_sys) begin // RQ6
        if (rst) begin
            osc_cnt_r <= 16'h0000;
            mod_cnt_r <= 4'h0;
            osc_tick  <= 1'b0;
            mod_tick  <= 1'b0;
        end else begin
            osc_tick  <= osc_wrap;
            osc_cnt_r <= osc_wrap ? 16'(OSC_DIV - 1) : osc_cnt_r - 16'h0001;
            mod_tick  <= osc_wrap && (mod_cnt_r == 4'h0);
            if (osc_wrap) begin
                mod_cnt_r <= (mod_cnt_r == 4'h0) ?
                             4'((5'h02 << clkdiv) - 5'h01) : mod_cnt_r - 4'h1;
            end
        end
    end
endmodule : osc_tick_gen

`default_nettype wire

/* File: logic/sequencer_params.svh */
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH

`define CTRL_OFS        5'h00
`define OPTION_OFS      5'h04
`define STATUS_OFS      5'h08
`define DATA_OFS        5'h0c
`define OFFSET_OFS      5'h10
`define GAIN_OFS        5'h14

`define MODE_FIELD      3:0
`define OSR_FIELD       5:4
`define CLKDIV_FIELD    7:6
`define ANALOG_AUTO_SLEEP_BIT     0

`define MODE_IDLE       4'h0
`define MODE_SLEEP      4'h1
`define MODE_SINGLE     4'h2
`define MODE_CONT       4'h3
`define MODE_SGL_CHOP   4'h4
`define MODE_CNT_CHOP   4'h5
`define MODE_SGL_IEX    4'h6
`define MODE_CNT_IEX    4'h7
`define MODE_CAL_OFS    4'hc
`define MODE_CAL_GAIN   4'hd
`define MODE_BOOT       4'hf

`define OSR_SEL_RST     2'h0
`define CLKDIV_RST      2'h0
`define ANALOG_AUTO_SLEEP_RST     1'b0
`define OSR_MAX         10'h200

`define SYS_CLK_MHZ     250
`define STARTUP_US      600
`define SETUP_US        10
`define WAKE_US         70
`define STARTUP_CYC     (`STARTUP_US * `SYS_CLK_MHZ)
`define SETUP_CYC       (`SETUP_US * `SYS_CLK_MHZ)
`define WAKE_CYC        (`WAKE_US * `SYS_CLK_MHZ)
`define OSC_DIV_DEFAULT 100
`define TCAL_OSC        40
`define TDIV_OSC        70
`define PERIODS_PLAIN   3
`define PERIODS_CHOP    6

`endif

/* File: logic/sequencer_pkg.sv */
// Types and mode decoding shared by the sequencer files
`include "sequencer_params.svh"

package sequencer_pkg;

    typedef enum logic [2:0] {
        ST_BOOT, ST_IDLE, ST_SLEEP, ST_SETTLE, ST_CONVERT, ST_CORRECT,
        ST_DIVIDE
    } seq_state_t;

    function automatic logic mode_unused(input logic [3:0] m);
        return (m[3:2] == 2'b10) || (m == 4'he) || (m == `MODE_BOOT);
    endfunction : mode_unused

    function automatic logic is_op(input logic [3:0] m);
        return !mode_unused(m) && (m != `MODE_IDLE) && (m != `MODE_SLEEP);
    endfunction : is_op

    function automatic logic is_single(input logic [3:0] m);
        return (m == `MODE_SINGLE) || (m == `MODE_SGL_CHOP) ||
               (m == `MODE_SGL_IEX);
    endfunction : is_single

    function automatic logic is_chop(input logic [3:0] m);
        return (m == `MODE_SGL_CHOP) || (m == `MODE_CNT_CHOP) ||
               (m == `MODE_SGL_IEX) || (m == `MODE_CNT_IEX);
    endfunction : is_chop

    function automatic logic is_iex(input logic [3:0] m);
        return (m == `MODE_SGL_IEX) || (m == `MODE_CNT_IEX);
    endfunction : is_iex

endpackage : sequencer_pkg

/* File: logic/sinc3_decimator.sv */
// Third-order sinc decimator for the one-bit modulator stream
`timescale 1ns/1ps
`default_nettype none

module sinc3_decimator #(
    parameter int ACC_W = 29
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             mod_tick,
    input  wire logic             bit_in,
    input  wire logic [9:0]       oversampling_ratio,
    output var  logic             dec_valid,
    output var  logic [ACC_W-1:0] dec_data
);
    logic [ACC_W-1:0] i1_r, i2_r, i3_r, z1_r, z2_r, z3_r;
    logic [9:0]       dcnt_r;
    // Wrap-around arithmetic is exact as long as ACC_W covers OVERSAMPLING_RATIO^3
    wire  [ACC_W-1:0] x  = bit_in ? ACC_W'(1) : {ACC_W{1'b1}};
    wire  [ACC_W-1:0] i1n = i1_r + x;
    wire  [ACC_W-1:0] i2n = i2_r + i1n;
    wire  [ACC_W-1:0] i3n = i3_r + i2n;
    wire  [ACC_W-1:0] d1 = i3n - z1_r;
    wire  [ACC_W-1:0] d2 = d1 - z2_r;
    wire  [ACC_W-1:0] d3 = d2 - z3_r;
    wire              last = (dcnt_r == oversampling_ratio - 10'h001);

    always_ff @(posedge clk_sys) begin // RQ4 RQ5
        if (rst || clear) begin
            {i1_r, i2_r, i3_r, z1_r, z2_r, z3_r} <= '0;
            dcnt_r    <= 10'h000;
            dec_valid <= 1'b0;
            dec_data  <= '0;
        end else begin
            dec_valid <= mod_tick && last;
            if (mod_tick) begin
                i1_r   <= i1n;
                i2_r   <= i2n;
                i3_r   <= i3n;
                dcnt_r <= last ? 10'h000 : dcnt_r + 10'h001;
                if (last) begin
                    z1_r     <= i3n;
                    z2_r     <= d1;
                    z3_r     <= d2;
                    dec_data <= d3;
                end
            end
        end
    end
endmodule : sinc3_decimator

`default_nettype wire

/* File: test/adc_conversion_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer
`include "sequencer_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer_tb;
    localparam int OD = 4;
    localparam int TB = 64 * OD * 2;
    localparam int TC = 40 * OD;
    logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
    logic        modulator_bit, not_ready_flag, analog_power;
    logic        chop_swap, excitation_swap, sw_seen, iex_seen;
    logic [4:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd_v;
    int          mismatches, n_tests, n, per;
    time         t0;

    adc_conversion_sequencer #(.STARTUP_CYC(50), .WAKE_CYC(40),
        .OSC_DIV(OD)) dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .modulator_bit(modulator_bit),
        .not_ready_flag(not_ready_flag), .chop_swap(chop_swap),
        .excitation_swap(excitation_swap), .analog_power(analog_power));
    modulator_model model (.clk_sys(clk_sys), .rst(rst),
        .modulator_bit(modulator_bit));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd_v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    // Times a mode from its write to the end of the first stored result
    task run(input logic [7:0] m, input int exp);
        bus(1'b1, `CTRL_OFS, 32'h30 | m);
        n = 0;
        sw_seen = 1'b0;
        iex_seen = 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
            sw_seen |= chop_swap;
            iex_seen |= excitation_swap;
        end while (n < 3 || not_ready_flag !== 1'b0);
        chk(n > exp - 24 && n < exp + 24, 1);
    endtask : run

    task summarize;
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Tests take about 60k cycles; give up at 100k
    initial begin
        #400000;
        mismatches++;
        summarize;
    end

    initial begin
        {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        rst = 1'b1;
        avs_byteenable = 4'h1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, `CTRL_OFS, 0);
        chk(rd_v[3:0], 4'hf);
        repeat (60) @(posedge clk_sys);
        bus(1'b0, `CTRL_OFS, 0);
        chk(rd_v[3:0], 4'h0);
        for (int c = 8; c < 15; c++) if (c < 12 || c == 14) begin
            bus(1'b1, `CTRL_OFS, 32'h30 | c);
            bus(1'b0, `STATUS_OFS, 0);
            chk(rd_v[6:3], 4'h1);
        end
        bus(1'b0, 5'h18, 0);
        chk(rd_v, 0);
        $display("boot and unused codes done");
        for (int m = 2; m < 8; m += 2) begin
            per = (m == 2) ? 3 : 6;
            run(m[3:0], `SETUP_CYC + per * TB + TC);
            chk(sw_seen, m != 2);
            chk(iex_seen, m == 6);
            bus(1'b0, `CTRL_OFS, 0);
            chk(rd_v[3:0], 4'h0);
        end
        $display("single modes done");
        for (int m = 3; m < 8; m += 2) begin
            per = (m == 3) ? 3 : 6;
            run(m[3:0], `SETUP_CYC + per * TB + TC);
            n = 0;
            do begin @(posedge clk_sys); n++; end while (not_ready_flag !== 1);
            do begin @(posedge clk_sys); n++; end while (not_ready_flag !== 0);
            chk(n > per * TB + TC - 24 && n < per * TB + TC + 24, 1);
            bus(1'b0, `CTRL_OFS, 0);
            chk(rd_v[3:0], m);
            bus(1'b1, `CTRL_OFS, 32'h30);
        end
        $display("continuous modes done");
        for (int m = 12; m < 14; m++) begin
            bus(1'b1, `CTRL_OFS, 32'h30 | m);
            t0 = $time;
            bus(1'b0, `CTRL_OFS, 0);
            chk(rd_v[3:0], m);
            do bus(1'b0, `CTRL_OFS, 0); while (rd_v[3:0] !== 4'h0);
            n = ($time - t0) / 4 - (`SETUP_CYC + 3 * TB + TC);
            n = n - ((m == 13) ? 70 * OD : 0);
            chk(n > -24 && n < 24, 1);
            bus(1'b0, `STATUS_OFS, 0);
            chk(rd_v[6:3], 4'h1);
        end
        $display("calibration done");
        // Clock divider 1 halves the modulator rate, doubling each period
        run(8'h72, `SETUP_CYC + 6 * TB + TC);
        $display("clock divider done");
        bus(1'b1, `CTRL_OFS, 32'h31);
        bus(1'b0, `STATUS_OFS, 0);
        chk({rd_v[1], analog_power}, 0);
        run(4'h2, 40 + 3 * TB + TC);
        $display("sleep and wake done");
        bus(1'b1, `OPTION_OFS, 1);
        bus(1'b0, `STATUS_OFS, 0);
        chk(rd_v[1], 0);
        run(4'h2, 40 + 3 * TB + TC);
        $display("auto-sleep wake done");
        summarize;
    end
endmodule : adc_conversion_sequencer_tb

`default_nettype wire

/* File: test/modulator_model.sv */
// Modulator bitstream source standing in for the analog loop
`timescale 1ns/1ps
`default_nettype none

module modulator_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    output var  logic modulator_bit
);
    logic [2:0] ph_r;

    // Changes on four of every eight cycles; the bench never reads the converted data, so a stuck input would go unseen
    always_ff @(posedge clk_sys) begin
        if (rst) ph_r <= 3'h0;
        else ph_r <= ph_r + 3'h1;
    end
    assign modulator_bit = (ph_r != 3'h3) && (ph_r != 3'h6);
endmodule : modulator_model

`default_nettype wire
